// ==== shared/mdr_pkg.sv ====
// Constants, types and register map of the multiply/divide register block
`default_nettype none
package mdr_pkg;
  // Data widths
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int CTRL_W = 8;
  localparam int ADDR_W = 8;

  typedef logic [ADDR_W-1:0] mdr_addr_type;
  typedef logic [WORD_W-1:0] mdr_word_type;
  typedef logic [HALF_W-1:0] mdr_half_type;
  typedef logic [CTRL_W-1:0] mdr_ctrl_type;
  typedef logic [5:0]        mdr_step_type;
  typedef logic [3:0]        mdr_strb_type;

  // Register byte addresses
  localparam mdr_addr_type OFF_A_LOW  = 8'h00;
  localparam mdr_addr_type OFF_A_HIGH = 8'h04;
  localparam mdr_addr_type OFF_B_LOW  = 8'h08;
  localparam mdr_addr_type OFF_B_HIGH = 8'h0c;
  localparam mdr_addr_type OFF_C_LOW  = 8'h10;
  localparam mdr_addr_type OFF_C_HIGH = 8'h14;
  localparam mdr_addr_type OFF_CTRL   = 8'h18;

  // Reset values
  localparam mdr_half_type HALF_RESET = 16'h0000;
  localparam mdr_ctrl_type CTRL_RESET = 8'h00;
  localparam mdr_word_type WORD_ZERO  = 32'h0000_0000;

  // Control register fields
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_RUN_BIT  = 0;
  localparam mdr_ctrl_type CTRL_DIV_ACTIVE = 8'h81;

  // Byte lanes that make up one full half-word access
  localparam mdr_strb_type LANES_HALF = 4'h3;

  // Divider timing: one quotient bit per cycle
  localparam int DIV_STEPS = 32;
  localparam mdr_step_type LAST_STEP = 6'(DIV_STEPS - 1);

  typedef enum logic [0:0]
  {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } mdr_div_state_type;
endpackage
`default_nettype wire

// ==== shared/mdr_div_if.sv ====
// Link between the register file and the divide engine
`timescale 1ns/1ps
`default_nettype none
interface mdr_div_if;
  import mdr_pkg::*;
  logic         start;
  mdr_word_type dividend;
  mdr_word_type divisor;
  logic         busy;
  logic         done;
  mdr_word_type quotient;
  mdr_word_type remainder;

  modport ctrl (output start, output dividend, output divisor,
                input busy, input done, input quotient, input remainder);
  modport unit (input start, input dividend, input divisor,
                output busy, output done, output quotient,
                output remainder);
endinterface
`default_nettype wire

// ==== logic/mdr_divider.sv ====
// Restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module mdr_divider
(
  input wire logic    clk,
  input wire logic    nrst,
  mdr_div_if.unit     bus
);
  import mdr_pkg::*;

  mdr_div_state_type state;
  mdr_step_type      step_cnt;
  mdr_word_type      quo;
  mdr_word_type      rem;
  mdr_word_type      dvs;
  logic              done;
  logic [WORD_W:0]   shifted;
  logic [WORD_W:0]   trial;
  logic              fits;

  // Trial subtraction of the divisor from the shifted remainder
  always_comb
  begin
    shifted = {rem, quo[WORD_W-1]};
    trial   = shifted - {1'b0, dvs};
    fits    = !trial[WORD_W];
  end

  // Sequencer: load on start, then shift in one quotient bit per cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state    <= DIV_IDLE;
      step_cnt <= '0;
      quo      <= WORD_ZERO;
      rem      <= WORD_ZERO;
      dvs      <= WORD_ZERO;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        DIV_IDLE:
        begin
          if (bus.start)
          begin
            state    <= DIV_RUN;
            step_cnt <= '0;
            quo      <= bus.dividend; // Latched dividend copy
            rem      <= WORD_ZERO;
            dvs      <= bus.divisor;
          end
        end
        DIV_RUN:
        begin
          quo      <= {quo[WORD_W-2:0], fits};
          rem      <= fits ? trial[WORD_W-1:0] : shifted[WORD_W-1:0];
          step_cnt <= step_cnt + 6'h01;
          if (step_cnt == LAST_STEP)
          begin
            state <= DIV_IDLE;
            done  <= 1'b1;
          end
        end
        default:
        begin
          state <= DIV_IDLE;
        end
      endcase
    end
  end

  assign bus.busy      = (state == DIV_RUN);
  assign bus.done      = done;
  assign bus.quotient  = quo;
  assign bus.remainder = rem;

  div_length_a: assert property (
    @(posedge clk) disable iff (!nrst)
    bus.start && state == DIV_IDLE |-> ##33 done)
    else $error("divide did not finish in 33 cycles");

  div_busy_span_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(bus.busy) |-> bus.busy [*8])
    else $error("divider dropped busy early");
endmodule
`default_nettype wire

// ==== logic/mdr_top.sv ====
// APB register file of the 16-bit multiplier and 32-bit divider with its divide engine
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mdr_top
(
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire mdr_pkg::mdr_addr_type paddr,
  input  wire mdr_pkg::mdr_word_type pwdata,
  input  wire mdr_pkg::mdr_strb_type pstrb,
  output var  mdr_pkg::mdr_word_type prdata,
  output logic                pready,
  output logic                pslverr
);
  import mdr_pkg::*;

  mdr_half_type a_low;
  mdr_half_type a_high;
  mdr_half_type b_low;
  mdr_half_type b_high;
  mdr_half_type c_low;
  mdr_half_type c_high;
  logic         divide_select;
  logic         run;
  mdr_ctrl_type ctrl_view;
  logic         setup_phase;
  logic         access_phase;
  logic         addr_ok;
  logic         full_lanes;
  logic         wr_ok;
  logic         start;
  mdr_word_type next_rdata;

  mdr_div_if div_bus ();

  // Divide engine
  mdr_divider u_divider
  (
    .clk  (clk),
    .nrst (nrst),
    .bus  (div_bus)
  );

  // Bus phase decode
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign full_lanes   = (pstrb & LANES_HALF) == LANES_HALF;

  // Address decode for mapped registers
  always_comb
  begin
    case (paddr)
      OFF_A_LOW, OFF_A_HIGH, OFF_B_LOW, OFF_B_HIGH,
      OFF_C_LOW, OFF_C_HIGH, OFF_CTRL:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; errors for unmapped or partial writes
  assign pready  = 1'b1;
  assign pslverr = access_phase
                   && (!addr_ok || (pwrite && !full_lanes));
  assign wr_ok   = access_phase && pwrite && addr_ok && full_lanes;

  // Control view: bit 7 mode, bit 0 division running
  always_comb
  begin
    ctrl_view = CTRL_RESET;
    ctrl_view[CTRL_MODE_BIT] = divide_select;
    ctrl_view[CTRL_RUN_BIT]  = run;
  end

  // Start a division when software writes mode and run together
  assign start = wr_ok && paddr == OFF_CTRL && !run
                 && pwdata[CTRL_MODE_BIT] && pwdata[CTRL_RUN_BIT];

  assign div_bus.start    = start;
  assign div_bus.dividend = {a_high, a_low};
  assign div_bus.divisor  = {b_high, b_low};

  // Mode select; locked while a division runs
  always_ff @(posedge clk)
  begin
    if (!nrst)
      divide_select <= CTRL_RESET[CTRL_MODE_BIT];
    else if (wr_ok && paddr == OFF_CTRL && !run)
      divide_select <= pwdata[CTRL_MODE_BIT];
  end

  // Running flag; control reads 81H while set
  always_ff @(posedge clk)
  begin
    if (!nrst)
      run <= CTRL_RESET[CTRL_RUN_BIT];
    else if (start)
      run <= 1'b1;
    else if (div_bus.done)
      run <= 1'b0;
  end

  // Operand pair A: software writes, quotient writeback wins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      a_low  <= HALF_RESET;
      a_high <= HALF_RESET;
    end
    else if (div_bus.done)
    begin
      a_high <= div_bus.quotient[WORD_W-1:HALF_W];
      a_low  <= div_bus.quotient[HALF_W-1:0];
    end
    else if (wr_ok && paddr == OFF_A_LOW)
      a_low <= pwdata[HALF_W-1:0];
    else if (wr_ok && paddr == OFF_A_HIGH)
      a_high <= pwdata[HALF_W-1:0];
  end

  // Divisor pair B
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      b_low  <= HALF_RESET;
      b_high <= HALF_RESET;
    end
    else if (wr_ok && paddr == OFF_B_LOW)
      b_low <= pwdata[HALF_W-1:0];
    else if (wr_ok && paddr == OFF_B_HIGH)
      b_high <= pwdata[HALF_W-1:0];
  end

  // Result pair C: product in multiply mode, remainder after a division
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      c_low  <= HALF_RESET;
      c_high <= HALF_RESET;
    end
    else if (!divide_select && !run)
      {c_high, c_low} <= mdr_word_type'(a_high) * mdr_word_type'(a_low);
    else if (div_bus.done)
      {c_high, c_low} <= div_bus.remainder;
  end

  // Read mux, upper bits read as zero
  always_comb
  begin
    case (paddr)
      OFF_A_LOW:  next_rdata = {{HALF_W{1'b0}}, a_low};
      OFF_A_HIGH: next_rdata = {{HALF_W{1'b0}}, a_high};
      OFF_B_LOW:  next_rdata = {{HALF_W{1'b0}}, b_low};
      OFF_B_HIGH: next_rdata = {{HALF_W{1'b0}}, b_high};
      OFF_C_LOW:  next_rdata = {{HALF_W{1'b0}}, c_low};
      OFF_C_HIGH: next_rdata = {{HALF_W{1'b0}}, c_high};
      OFF_CTRL:   next_rdata = {{(WORD_W-CTRL_W){1'b0}}, ctrl_view};
      default:    next_rdata = WORD_ZERO;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      prdata <= WORD_ZERO;
    else if (setup_phase && !pwrite)
      prdata <= next_rdata;
  end

  reset_a_clear_a: assert property (
    @(posedge clk) !nrst |=> a_low == HALF_RESET && a_high == HALF_RESET)
    else $error("A not cleared by reset");

  reset_bc_clear_a: assert property (
    @(posedge clk) !nrst |=> {b_high, b_low, c_high, c_low} == '0)
    else $error("B or C not cleared by reset");

  reset_ctrl_clear_a: assert property (
    @(posedge clk) !nrst |=> ctrl_view == CTRL_RESET)
    else $error("control not cleared by reset");

  quotient_wb_a: assert property (
    @(posedge clk) disable iff (!nrst)
    div_bus.done |=> {a_high, a_low} == $past(div_bus.quotient))
    else $error("quotient not written to A");

  partial_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    access_phase && pwrite && !full_lanes && !div_bus.done
      |=> $stable(a_low) && $stable(a_high))
    else $error("partial write changed A");

  product_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !divide_select && !run |=>
      {c_high, c_low} == $past(a_high) * $past(a_low))
    else $error("product in C is wrong");

  active_ctrl_a: assert property (
    @(posedge clk) disable iff (!nrst)
    div_bus.busy |-> ctrl_view == CTRL_DIV_ACTIVE)
    else $error("control not 81H during division");

  start_mode_a: assert property (
    @(posedge clk) disable iff (!nrst)
    start |=> divide_select && run ##33 !run)
    else $error("division start or end misplaced");

  read_live_a: assert property (
    @(posedge clk) disable iff (!nrst)
    setup_phase && !pwrite && paddr == OFF_A_LOW
      |=> prdata == {{HALF_W{1'b0}}, $past(a_low)})
    else $error("A low read back wrong");
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench of the multiply/divide register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mdr_pkg::*;
  logic         clk;
  logic         nrst;
  logic         psel;
  logic         penable;
  logic         pwrite;
  mdr_addr_type paddr;
  mdr_word_type pwdata;
  mdr_strb_type pstrb;
  mdr_word_type prdata;
  logic         pready;
  logic         pslverr;
  int           fail_count;
  int           num_checks;
  logic [31:0]  seed;
  mdr_word_type rd;
  logic         err;
  mdr_word_type dd;
  mdr_word_type dv;
  mdr_half_type hi;
  mdr_half_type lo;

  mdr_top mdr_top_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  // Next value of the repeatable xorshift stream
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Expected quotient and remainder; all-ones quotient and the dividend as remainder on a zero divisor
  function automatic mdr_word_type quot(input mdr_word_type a,
                                        input mdr_word_type b);
    return (b == WORD_ZERO) ? 32'hffff_ffff : a / b;
  endfunction

  function automatic mdr_word_type remd(input mdr_word_type a,
                                        input mdr_word_type b);
    return (b == WORD_ZERO) ? a : a % b;
  endfunction

  // Error expected on an unmapped or unaligned address
  function automatic logic bad_addr(input mdr_addr_type a);
    return (a > OFF_CTRL) || (a[1:0] != 2'b00);
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input mdr_word_type got, input mdr_word_type exp,
                       input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input mdr_addr_type a,
                     input mdr_word_type d, input mdr_strb_type s);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    check(32'(n), 32'h1, "wait states");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr16(input mdr_addr_type a, input mdr_half_type v);
    apb(1'b1, a, {16'h0000, v}, 4'hf);
  endtask

  task automatic rd_chk(input mdr_addr_type a, input mdr_word_type e);
    apb(1'b0, a, WORD_ZERO, 4'h0);
    check(rd, e, "read");
    check({31'h0, err}, {31'h0, bad_addr(a)}, "read err");
  endtask

  // Start a division and poll the run bit until it drops
  task automatic divide(input logic poke);
    wr16(OFF_A_HIGH, dd[31:16]);
    wr16(OFF_A_LOW, dd[15:0]);
    wr16(OFF_B_LOW, dv[15:0]);
    wr16(OFF_B_HIGH, dv[31:16]);
    wr16(OFF_CTRL, 16'h0081);
    rd_chk(OFF_CTRL, 32'h81);
    if (poke)
      wr16(OFF_A_LOW, 16'h5a5a);
    do
    begin
      apb(1'b0, OFF_CTRL, WORD_ZERO, 4'h0);
    end
    while (rd[0] !== 1'b0);
    check(rd, 32'h80, "ctrl after divide");
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial
  begin
    clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; seed = 32'd21;
    fail_count = 0; num_checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // Every register reads zero after reset
    for (int a = 0; a <= 8'h18; a += 4)
      rd_chk(8'(a), WORD_ZERO);
    // Unmapped read gives zero with an error
    rd_chk(8'h1c, WORD_ZERO);
    check({31'h0, err}, 32'h1, "unmapped err");
    // Partial write into A is refused
    wr16(OFF_A_LOW, 16'h1234);
    apb(1'b1, OFF_A_LOW, 32'h0000_abcd, 4'h1);
    check({31'h0, err}, 32'h1, "strobe err");
    rd_chk(OFF_A_LOW, 32'h1234);
    // Divisions: zero, one, then random divisors
    for (int i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      dd = (i == 2) ? 32'hffff_ffff : seed;
      seed = xs(seed);
      dv = (i == 0) ? WORD_ZERO : (i == 1) ? 32'h1 : seed >> seed[4:0];
      divide(1'b0);
      rd_chk(OFF_A_LOW, quot(dd, dv) & 32'h0000_ffff);
      rd_chk(OFF_A_HIGH, quot(dd, dv) >> 16);
      rd_chk(OFF_C_LOW, remd(dd, dv) & 32'h0000_ffff);
      rd_chk(OFF_C_HIGH, remd(dd, dv) >> 16);
    end
    // A write in mid-division does not stop the operation
    divide(1'b1);
    rd_chk(OFF_A_LOW, quot(dd, dv) & 32'h0000_ffff);
    // Back to multiply mode, then the all-ones product and random products
    wr16(OFF_CTRL, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      hi = (i == 0) ? 16'hffff : seed[31:16];
      lo = (i == 0) ? 16'hffff : seed[15:0];
      wr16(OFF_A_HIGH, hi);
      wr16(OFF_A_LOW, lo);
      dd = {16'h0, hi} * {16'h0, lo};
      rd_chk(OFF_C_LOW, {16'h0, dd[15:0]});
      rd_chk(OFF_C_HIGH, {16'h0, dd[31:16]});
    end
    close_out();
  end
endmodule
`default_nettype wire
